// ### rtl/periph_consts.svh
// Purpose: named addresses, field positions, reset values and codes
// Assumes: included by the package and by the register block
// Notes:   definitions only
`ifndef PERIPH_CONSTS_SVH
`define PERIPH_CONSTS_SVH

// register byte addresses on the bus
`define ADDR_ENABLE_A     32'h02ac0008
`define ADDR_STATE_A      32'h02ac0014
`define ADDR_STATE_B      32'h02ac0018
`define ADDR_ETH_CFG      32'h02ac0020
`define ADDR_TRACE_PD     32'h02ac0054

// reset values and the enable write mask
`define ENABLE_A_RESET    32'h00000000
`define ETH_CFG_RESET     32'h000c0000
`define ENABLE_A_MASK     32'h00155550

// single-bit fields
`define ETH_RMII_RST_BIT  18
`define TRACE_OFF_BIT     0

// shared peripheral status codes
`define ST_DISABLED       3'h0
`define ST_ENABLED        3'h1
`define ST_POWERDOWN      3'h3
`define ST_IN_PROGRESS    3'h5

// peripheral count and indices
`define NUM_PERIPH        9
`define PI_EMAC           0
`define PI_TIMER0         1
`define PI_TIMER1         2
`define PI_GPIO           3
`define PI_I2C            4
`define PI_SP0            5
`define PI_SP1            6
`define PI_HPI            7
`define PI_PCI            8

// enable bit positions in peripheral_enable_a
`define EN_EMAC           4
`define EN_TIMER1         6
`define EN_TIMER0         8
`define EN_GPIO           10
`define EN_I2C            12
`define EN_SP0            14
`define EN_SP1            16
`define EN_HPI            18
`define EN_PCI            20

// status field low bits
`define POS_EMAC          6
`define POS_TIMER0        9
`define POS_TIMER1        12
`define POS_GPIO          15
`define POS_I2C           18
`define POS_SP0           21
`define POS_SP1           24
`define POS_HPI           27
`define POS_PCI           0

// bus responses
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

// ### rtl/periph_pkg.sv
// Purpose: shared types of the peripheral state and config registers
// Assumes: constants come from periph_consts.svh
// Notes:   one-hot power states, packed state records per module
`include "periph_consts.svh"

package periph_pkg;

  // per-peripheral power sequence
  typedef enum logic [3:0] {
    P_OFF   = 4'h1,
    P_WAKE  = 4'h2,
    P_ON    = 4'h4,
    P_SLEEP = 4'h8
  } power_state_t;

  typedef logic [2:0] status_code_t;

  // register selected by an address
  typedef enum logic [2:0] {
    SEL_NONE, SEL_ENABLE_A, SEL_STATE_A, SEL_STATE_B, SEL_ETH, SEL_TRACE
  } reg_sel_t;

  typedef struct packed {
    power_state_t [`NUM_PERIPH-1:0] st;
  } seq_state_t;

  typedef struct packed {
    logic        aw_held;
    logic [31:0] awaddr;
    logic        w_held;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [31:0] enable_a;
    logic [31:0] eth_cfg;
    logic        trace_off;
  } regs_state_t;

endpackage

// ### rtl/periph_power_if.sv
// Purpose: carries enables, readiness and status between block parts
// Assumes: all signals on aclk
// Notes:   status holds one 3-bit code per peripheral
`include "periph_consts.svh"

interface periph_power_if;
  logic [`NUM_PERIPH-1:0]                 enable;
  logic [`NUM_PERIPH-1:0]                 ready;
  logic [`NUM_PERIPH-1:0]                 sleep;
  periph_pkg::status_code_t [`NUM_PERIPH-1:0] status;

  modport ctl  (output enable, output ready, output sleep, input status);
  modport seq  (input enable, input ready, input sleep, output status);
  modport view (input status);
endinterface

// ### rtl/periph_power_seq.sv
// Purpose: per-peripheral power state tracking and status codes
// Assumes: enable, ready and sleep are on aclk
// Notes:   one sequencer covers all peripherals in a for loop; a generate loop maps the status codes
`include "periph_consts.svh"

module periph_power_seq (
  // clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // peripheral control and status
  periph_power_if.seq       pw
);

  periph_pkg::seq_state_t r;
  periph_pkg::seq_state_t next_r;

  // only documented codes can leave this function
  function automatic periph_pkg::status_code_t code_of(
    input periph_pkg::power_state_t s);
    unique case (s)
      periph_pkg::P_WAKE:  code_of = `ST_IN_PROGRESS;
      periph_pkg::P_ON:    code_of = `ST_ENABLED;
      periph_pkg::P_SLEEP: code_of = `ST_POWERDOWN;
      default:             code_of = `ST_DISABLED;
    endcase
  endfunction

  // next state for each peripheral
  always_comb begin
    next_r = r;
    for (int i = 0; i < `NUM_PERIPH; i++) begin
      if (!pw.enable[i]) begin
        next_r.st[i] = periph_pkg::P_OFF;
      end else begin
        unique case (r.st[i])
          periph_pkg::P_OFF:   next_r.st[i] = periph_pkg::P_WAKE;
          periph_pkg::P_WAKE:  next_r.st[i] = pw.ready[i] ?
                                 periph_pkg::P_ON : periph_pkg::P_WAKE;
          periph_pkg::P_ON:    next_r.st[i] = pw.sleep[i] ?
                                 periph_pkg::P_SLEEP : periph_pkg::P_ON;
          periph_pkg::P_SLEEP: next_r.st[i] = pw.sleep[i] ?
                                 periph_pkg::P_SLEEP : periph_pkg::P_ON;
          default:             next_r.st[i] = periph_pkg::P_OFF;
        endcase
      end
    end
  end

  // state registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < `NUM_PERIPH; i++) begin
        r.st[i] <= periph_pkg::P_OFF;
      end
    end else begin
      r <= next_r;
    end
  end

  // status code per peripheral
  genvar g;
  generate
    for (g = 0; g < `NUM_PERIPH; g++) begin : g_code
      assign pw.status[g] = code_of(r.st[g]);
    end
  endgenerate

endmodule // periph_power_seq

// ### rtl/status_pack.sv
// Purpose: places peripheral status codes into the two status words
// Assumes: status codes are always legal
// Notes:   reserved bits read as zero
`include "periph_consts.svh"

module status_pack (
  // status source
  periph_power_if.view      pw,
  // packed words
  output logic [31:0]       state_a,
  output logic [31:0]       state_b
);

  // first status word
  always_comb begin
    state_a = 32'h00000000;
    state_a[`POS_HPI+:3]    = pw.status[`PI_HPI];
    state_a[`POS_SP1+:3]    = pw.status[`PI_SP1];
    state_a[`POS_SP0+:3]    = pw.status[`PI_SP0];
    state_a[`POS_I2C+:3]    = pw.status[`PI_I2C];
    state_a[`POS_GPIO+:3]   = pw.status[`PI_GPIO];
    state_a[`POS_TIMER1+:3] = pw.status[`PI_TIMER1];
    state_a[`POS_TIMER0+:3] = pw.status[`PI_TIMER0];
    state_a[`POS_EMAC+:3]   = pw.status[`PI_EMAC];
  end

  // second status word
  always_comb begin
    state_b = 32'h00000000;
    state_b[`POS_PCI+:3] = pw.status[`PI_PCI];
  end

endmodule // status_pack

// ### rtl/peripheral_state_config_regs.sv
// Purpose: peripheral status, ethernet config and trace buffer
//          power registers behind an AXI4-Lite slave
// Assumes: one clock aclk (40 MHz), synchronous active-low aresetn;
//          periph_ready and sleep_req come from logic on aclk
// Notes:   one write and one read in flight at most
`include "periph_consts.svh"

module peripheral_state_config_regs (
  // clock and reset
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  // write address channel
  input  wire logic                   awvalid,
  output logic                        awready,
  input  wire logic [31:0]            awaddr,
  input  wire logic [2:0]             awprot,
  // write data channel
  input  wire logic                   wvalid,
  output logic                        wready,
  input  wire logic [31:0]            wdata,
  input  wire logic [3:0]             wstrb,
  // write response channel
  output logic                        bvalid,
  input  wire logic                   bready,
  output logic [1:0]                  bresp,
  // read address channel
  input  wire logic                   arvalid,
  output logic                        arready,
  input  wire logic [31:0]            araddr,
  input  wire logic [2:0]             arprot,
  // read data channel
  output logic                        rvalid,
  input  wire logic                   rready,
  output logic [31:0]                 rdata,
  output logic [1:0]                  rresp,
  // peripheral side
  output logic [`NUM_PERIPH-1:0]      periph_enable,
  input  wire logic [`NUM_PERIPH-1:0] periph_ready,
  input  wire logic [`NUM_PERIPH-1:0] sleep_req,
  // ethernet and trace control
  output logic                        rmii_reset,
  output logic                        trace_buffer_off
);

  periph_pkg::regs_state_t r;
  periph_pkg::regs_state_t next_r;

  periph_power_if pw ();

  logic [31:0]           state_a;
  logic [31:0]           state_b;
  logic [31:0]           merged;
  periph_pkg::reg_sel_t  wsel;
  periph_pkg::reg_sel_t  rsel;
  logic                  unused_prot;

  // enable bit position of each peripheral, indexed like the status codes
  localparam int EN_POS [`NUM_PERIPH] = '{
    `EN_EMAC, `EN_TIMER0, `EN_TIMER1, `EN_GPIO, `EN_I2C,
    `EN_SP0, `EN_SP1, `EN_HPI, `EN_PCI
  };

  // address decode shared by the read and write paths;
  // low two bits ignored, so unaligned addresses also match their word
  function automatic periph_pkg::reg_sel_t decode(input logic [31:0] a);
    logic [31:0] w;
    w = {a[31:2], 2'h0};
    if (w == `ADDR_ENABLE_A) begin
      decode = periph_pkg::SEL_ENABLE_A;
    end else if (w == `ADDR_STATE_A) begin
      decode = periph_pkg::SEL_STATE_A;
    end else if (w == `ADDR_STATE_B) begin
      decode = periph_pkg::SEL_STATE_B;
    end else if (w == `ADDR_ETH_CFG) begin
      decode = periph_pkg::SEL_ETH;
    end else if (w == `ADDR_TRACE_PD) begin
      decode = periph_pkg::SEL_TRACE;
    end else begin
      decode = periph_pkg::SEL_NONE;
    end
  endfunction

  // byte-lane merge of write data into an old register value
  function automatic logic [31:0] merge_bytes(input logic [31:0] old,
                                              input logic [31:0] data,
                                              input logic [3:0]  strb);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        m[8*b +: 8] = data[8*b +: 8];
      end
    end
    return m;
  endfunction

  // protection bits carry no meaning here
  assign unused_prot = ^{awprot, arprot};

  // peripheral power sequencers and status word packing
  periph_power_seq u_seq (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pw      (pw.seq)
  );

  status_pack u_pack (
    .pw      (pw.view),
    .state_a (state_a),
    .state_b (state_b)
  );

  // enables come straight from the enable register
  genvar g;
  generate
    for (g = 0; g < `NUM_PERIPH; g++) begin : g_en
      assign periph_enable[g] = r.enable_a[EN_POS[g]];
    end
  endgenerate

  // peripheral feedback into the sequencers
  assign pw.enable = periph_enable;
  assign pw.ready  = periph_ready;
  assign pw.sleep  = sleep_req;

  // decode of the held write address and of the incoming read address
  assign wsel   = decode(r.awaddr);
  assign rsel   = decode(araddr);
  assign merged = merge_bytes(r.eth_cfg, r.wdata, r.wstrb);

  // channel handshakes; no write is taken while bvalid waits, no read while rvalid waits
  assign awready = !r.aw_held && !r.bvalid;
  assign wready  = !r.w_held && !r.bvalid;
  assign arready = !r.rvalid;

  // register outputs
  assign bvalid           = r.bvalid;
  assign bresp            = r.bresp;
  assign rvalid           = r.rvalid;
  assign rdata            = r.rdata;
  assign rresp            = r.rresp;
  assign rmii_reset       = r.eth_cfg[`ETH_RMII_RST_BIT];
  assign trace_buffer_off = r.trace_off;

  // next-state logic of the bus slave and the writable registers
  always_comb begin
    next_r = r;

    // write address and data are taken in either order
    if (awvalid && awready) begin
      next_r.aw_held = 1'b1;
      next_r.awaddr  = awaddr;
    end
    if (wvalid && wready) begin
      next_r.w_held = 1'b1;
      next_r.wdata  = wdata;
      next_r.wstrb  = wstrb;
    end

    // both halves held: commit the write and raise the response
    if (r.aw_held && r.w_held) begin
      next_r.aw_held = 1'b0;
      next_r.w_held  = 1'b0;
      next_r.bvalid  = 1'b1;
      next_r.bresp   = `RESP_OKAY;
      unique case (wsel)
        periph_pkg::SEL_ENABLE_A: begin
          next_r.enable_a = merge_bytes(r.enable_a, r.wdata, r.wstrb)
                            & `ENABLE_A_MASK;
        end
        periph_pkg::SEL_ETH: begin
          // every strobed byte is stored as written; keeping the upper defaults
          // and the low zeros is up to software
          next_r.eth_cfg = merged;
        end
        periph_pkg::SEL_TRACE: begin
          if (r.wstrb[0]) begin
            next_r.trace_off = r.wdata[`TRACE_OFF_BIT];
          end
        end
        periph_pkg::SEL_STATE_A,
        periph_pkg::SEL_STATE_B: begin
          next_r.bresp = `RESP_OKAY;                       // read-only
        end
        periph_pkg::SEL_NONE: begin
          next_r.bresp = `RESP_SLVERR;
        end
      endcase
    end

    // response leaves when the master takes it
    if (r.bvalid && bready) begin
      next_r.bvalid = 1'b0;
    end

    // read: data sampled at the address handshake
    if (arvalid && arready) begin
      next_r.rvalid = 1'b1;
      next_r.rresp  = `RESP_OKAY;
      unique case (rsel)
        periph_pkg::SEL_ENABLE_A: next_r.rdata = r.enable_a;
        periph_pkg::SEL_STATE_A:  next_r.rdata = state_a;
        periph_pkg::SEL_STATE_B:  next_r.rdata = state_b;
        periph_pkg::SEL_ETH:      next_r.rdata = r.eth_cfg;
        periph_pkg::SEL_TRACE: begin
          next_r.rdata = 32'h00000000;
          next_r.rdata[`TRACE_OFF_BIT] = r.trace_off;
        end
        periph_pkg::SEL_NONE: begin
          next_r.rdata = 32'h00000000;
          next_r.rresp = `RESP_SLVERR;
        end
      endcase
    end else if (r.rvalid && rready) begin
      next_r.rvalid = 1'b0;
    end
  end

  // state register with synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r           <= '0;
      r.enable_a  <= `ENABLE_A_RESET;
      r.eth_cfg   <= `ETH_CFG_RESET;
      r.trace_off <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

endmodule // peripheral_state_config_regs

// ### dv/peripheral_state_config_regs_sva.sv
// Purpose: bus and control output checks of the register block
// Assumes: one clock aclk, synchronous active-low aresetn
// Notes:   bound to the top module
`include "periph_consts.svh"

module peripheral_state_config_regs_sva (
  // clock and reset
  input wire logic                   aclk,
  input wire logic                   aresetn,
  // bus channels
  input wire logic                   awvalid,
  input wire logic                   awready,
  input wire logic                   wvalid,
  input wire logic                   wready,
  input wire logic                   bvalid,
  input wire logic                   bready,
  input wire logic [1:0]             bresp,
  input wire logic                   arvalid,
  input wire logic                   arready,
  input wire logic                   rvalid,
  input wire logic                   rready,
  input wire logic [31:0]            rdata,
  // control outputs
  input wire logic [`NUM_PERIPH-1:0] periph_enable,
  input wire logic                   rmii_reset,
  input wire logic                   trace_buffer_off
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // reset values of the control outputs
  a_rmii_init: assert property (disable iff (1'b0)
    !aresetn |=> rmii_reset) else $error("rmii reset low after reset");
  a_trace_init: assert property (disable iff (1'b0)
    !aresetn |=> !trace_buffer_off) else $error("trace off after reset");
  a_enable_init: assert property (disable iff (1'b0)
    !aresetn |=> periph_enable == '0) else $error("enables after reset");
  // control outputs move only with a write response
  a_rmii_cause: assert property (
    $changed(rmii_reset) |-> $rose(bvalid)) else $error("rmii moved alone");
  a_trace_cause: assert property (
    $changed(trace_buffer_off) |-> $rose(bvalid))
    else $error("trace moved alone");
  a_enable_cause: assert property (
    $changed(periph_enable) |-> $rose(bvalid))
    else $error("enable moved alone");
  // answer timing and holding of responses
  a_write_answer: assert property (
    awvalid && awready && wvalid && wready |=> !bvalid ##1 bvalid)
    else $error("write response late");
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read response late");
  a_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  a_busy_refuse: assert property (bvalid |-> !awready && !wready && 1'b1)
    else $error("write taken while busy");
endmodule // peripheral_state_config_regs_sva

bind peripheral_state_config_regs peripheral_state_config_regs_sva u_sva (
  .aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid, .bready,
  .bresp, .arvalid, .arready, .rvalid, .rready, .rdata, .periph_enable,
  .rmii_reset, .trace_buffer_off);

// ### dv/test_peripheral_state_config_regs.sv
// Purpose: self-checking bench of the register block
// Assumes: 40 MHz aclk, synchronous active-low aresetn
// Notes:   fixed seed; random enables, sleep and bus stalls; ready all low, then all high
`include "periph_consts.svh"

module test_peripheral_state_config_regs;
  timeunit 1ns;
  timeprecision 1ps;

  logic                   aclk, aresetn, awvalid, awready, wvalid, wready;
  logic                   bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0]            awaddr, wdata, araddr, rdata, m;
  logic [3:0]             wstrb;
  logic [1:0]             bresp, rresp;
  logic [`NUM_PERIPH-1:0] periph_enable, periph_ready, sleep_req;
  logic                   rmii_reset, trace_buffer_off;
  int                     num_errors, total_checks;
  int pos[9] = '{`POS_EMAC, `POS_TIMER0, `POS_TIMER1, `POS_GPIO, `POS_I2C,
                 `POS_SP0, `POS_SP1, `POS_HPI, `POS_PCI};
  int enb[9] = '{`EN_EMAC, `EN_TIMER0, `EN_TIMER1, `EN_GPIO, `EN_I2C,
                 `EN_SP0, `EN_SP1, `EN_HPI, `EN_PCI};

  peripheral_state_config_regs dut (.aclk, .aresetn, .awvalid, .awready,
    .awaddr, .awprot(3'h0), .wvalid, .wready, .wdata, .wstrb, .bvalid,
    .bready, .bresp, .arvalid, .arready, .araddr, .arprot(3'h0), .rvalid,
    .rready, .rdata, .rresp, .periph_enable, .periph_ready, .sleep_req,
    .rmii_reset, .trace_buffer_off);

  // free-running clock
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  task automatic tally_and_finish();
    if (num_errors == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
    chk_word({30'h0, g}, {30'h0, e});
  endtask

  // bounded wait step
  task automatic tick(inout int n);
    @(negedge aclk);
    n++;
    if (n > 40) begin
      num_errors++;
      tally_and_finish();
    end
  endtask

  // write with both halves offered together, bready raised late at random
  task automatic wchk(input logic [31:0] a, input logic [31:0] d,
                      input logic [3:0] s, input logic [1:0] e);
    int   n, dly;
    logic ta, tw, tb;
    logic [1:0] r;
    n = 0;
    dly = $urandom_range(3);
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    bready <= (dly == 0);
    do begin
      tick(n);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid & bready;
      r = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      bready <= !tb && (bready || n >= dly);
    end while (!tb);
    chk_resp(r, e);
  endtask

  // read with rready raised late at random
  task automatic rchk(input logic [31:0] a, input logic [31:0] e,
                      input logic [1:0] re);
    int   n, dly;
    logic ta, tr;
    logic [31:0] d;
    logic [1:0] r;
    n = 0;
    dly = $urandom_range(3);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= (dly == 0);
    do begin
      tick(n);
      ta = arvalid & arready;
      tr = rvalid & rready;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      rready <= !tr && (rready || n >= dly);
    end while (!tr);
    chk_word(d, e);
    chk_resp(r, re);
  endtask

  // expected status word from enables, readiness and sleep requests
  function automatic logic [31:0] expw(logic b, logic [31:0] en,
                                       logic [8:0] rdy, logic [8:0] slp);
    logic [31:0] w;
    w = '0;
    for (int i = 0; i < 9; i++)
      if ((i == `PI_PCI) == b)
        w[pos[i]+:3] = !en[enb[i]] ? `ST_DISABLED : !rdy[i] ? `ST_IN_PROGRESS
                     : slp[i] ? `ST_POWERDOWN : `ST_ENABLED;
    return w;
  endfunction

  // expected enable outputs
  function automatic logic [31:0] en9(logic [31:0] en);
    logic [31:0] e;
    e = '0;
    for (int i = 0; i < 9; i++)
      e[i] = en[enb[i]];
    return e;
  endfunction

  // main sequence
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, wdata, araddr, wstrb, periph_ready, sleep_req} = '0;
    num_errors = 0;
    total_checks = 0;
    void'($urandom(83327));
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk_word({31'h0, rmii_reset}, 32'h1);
    chk_word({31'h0, trace_buffer_off}, 32'h0);
    rchk(`ADDR_STATE_A, 32'h0, `RESP_OKAY);
    rchk(`ADDR_STATE_B, 32'h0, `RESP_OKAY);
    rchk(`ADDR_ETH_CFG, `ETH_CFG_RESET, `RESP_OKAY);
    rchk(`ADDR_TRACE_PD, 32'h0, `RESP_OKAY);
    rchk(32'h02ac0030, 32'h0, `RESP_SLVERR);
    wchk(32'h02ac0030, 32'hffffffff, 4'hf, `RESP_SLVERR);
    wchk(`ADDR_STATE_A, 32'hffffffff, 4'hf, `RESP_OKAY);
    rchk(`ADDR_STATE_A, 32'h0, `RESP_OKAY);
    // rmii logic released, then held again
    wchk(`ADDR_ETH_CFG, 32'h00080000, 4'hf, `RESP_OKAY);
    chk_word({31'h0, rmii_reset}, 32'h0);
    rchk(`ADDR_ETH_CFG, 32'h00080000, `RESP_OKAY);
    wchk(`ADDR_ETH_CFG, `ETH_CFG_RESET, 4'hf, `RESP_OKAY);
    chk_word({31'h0, rmii_reset}, 32'h1);
    // trace buffers: reserved bits read zero, byte lane 0 honoured
    wchk(`ADDR_TRACE_PD, 32'hffffffff, 4'hf, `RESP_OKAY);
    rchk(`ADDR_TRACE_PD, 32'h1, `RESP_OKAY);
    wchk(`ADDR_TRACE_PD, 32'h0, 4'he, `RESP_OKAY);
    chk_word({31'h0, trace_buffer_off}, 32'h1);
    wchk(`ADDR_TRACE_PD, 32'h0, 4'h1, `RESP_OKAY);
    chk_word({31'h0, trace_buffer_off}, 32'h0);
    // random enables: waking, then on or static powerdown
    for (int k = 0; k < 8; k++) begin
      m = (k == 0) ? `ENABLE_A_MASK : $urandom() & `ENABLE_A_MASK;
      periph_ready <= '0;
      sleep_req <= '0;
      wchk(`ADDR_ENABLE_A, 32'h0, 4'hf, `RESP_OKAY);
      wchk(`ADDR_ENABLE_A, m, 4'hf, `RESP_OKAY);
      chk_word({23'h0, periph_enable}, en9(m));
      rchk(`ADDR_STATE_A, expw(0, m, 0, 0), `RESP_OKAY);
      rchk(`ADDR_STATE_B, expw(1, m, 0, 0), `RESP_OKAY);
      periph_ready <= '1;
      sleep_req <= 9'($urandom());
      repeat (3) @(posedge aclk);
      rchk(`ADDR_STATE_A, expw(0, m, '1, sleep_req), `RESP_OKAY);
      rchk(`ADDR_STATE_B, expw(1, m, '1, sleep_req), `RESP_OKAY);
    end
    tally_and_finish();
  end
endmodule // test_peripheral_state_config_regs
